// ===== logic/uaa_consts.svh
// Named offsets, field positions, reset values and defaults of the add slice.
`ifndef UAA_CONSTS_SVH
`define UAA_CONSTS_SVH

// ------------------------------------------------------------------
// Register offsets on the register port (byte addresses).
// ------------------------------------------------------------------
`define UAA_OFF_ACC 8'h00
`define UAA_OFF_PROD 8'h04
`define UAA_OFF_STATUS 8'h08
`define UAA_OFF_CTRL 8'h0c
`define UAA_OFF_OVC 8'h10
`define UAA_OFF_UCT 8'h14
`define UAA_OFF_RPT 8'h18
`define UAA_AUX_PAGE 3'h1
`define UAA_AUX_COUNT 8

// ------------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------------
`define UAA_ST_N 0
`define UAA_ST_Z 1
`define UAA_ST_C 2
`define UAA_ST_V 3
`define UAA_CTL_SAT 0
`define UAA_CTL_PTR_LO 4
`define UAA_CTL_PTR_HI 6

// ------------------------------------------------------------------
// Values and defaults.
// ------------------------------------------------------------------
`define UAA_SAT_POS 32'h7fffffff
`define UAA_SAT_NEG 32'h80000000
`define UAA_ZERO32 32'h00000000
`define UAA_TALLY_W_DEF 8
`define UAA_RPT_W_DEF 8

`endif

// ===== logic/uaa_pkg.sv
// Shared types of the add slice: operation codes and sequencer states.
package uaa_pkg;

	// Operation selected by the decoder.
	typedef enum logic [2:0] {
		UAA_OP_NONE = 3'b000,
		UAA_OP_ADD16 = 3'b001,
		UAA_OP_ADD32_P = 3'b010,
		UAA_OP_ADD32_ACC = 3'b011,
		UAA_OP_AUX_IMM = 3'b100
	} uaa_op_e;

	// Sequencer states.
	typedef enum logic {
		UAA_ST_IDLE = 1'b0,
		UAA_ST_RUN = 1'b1
	} uaa_state_e;

endpackage

// ===== logic/uaa_adder.sv
// Combinational 32-bit adder with carry, overflow and saturation.
`include "uaa_consts.svh"

module uaa_adder (
	// Operands.
	input wire logic [31:0] lhs,
	input wire logic [31:0] rhs,
	input wire logic sat_en,
	// Results.
	output logic [31:0] result,
	output logic carry,
	output logic ovf_pos,
	output logic ovf_neg
);

	// Sum with one extra bit so the carry out of bit 31 is kept.
	logic [32:0] full;

	assign full = {1'b0, lhs} + {1'b0, rhs};
	assign carry = full[32];

	// Overflow only when both signs agree and the result sign differs.
	assign ovf_pos = !lhs[31] && !rhs[31] && full[31];
	assign ovf_neg = lhs[31] && rhs[31] && !full[31];

	// Saturation clamps an overflowed sum to the nearest extreme.
	always_comb begin
		result = full[31:0];
		if (sat_en && ovf_pos) begin
			result = `UAA_SAT_POS;
		end else if (sat_en && ovf_neg) begin
			result = `UAA_SAT_NEG;
		end
	end

endmodule

// ===== logic/uaa_aux_file.sv
// Eight auxiliary registers with an immediate add and a software write.
`include "uaa_consts.svh"

module uaa_aux_file #(
	parameter int NREG = `UAA_AUX_COUNT
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Software write.
	input wire logic sw_we,
	input wire logic [2:0] sw_idx,
	input wire logic [31:0] sw_data,
	// Immediate add.
	input wire logic add_en,
	input wire logic [2:0] add_idx,
	input wire logic [7:0] add_imm,
	// Read port.
	input wire logic [2:0] rd_idx,
	output logic [31:0] rd_data
);

	// The 3-bit pointer reaches exactly eight entries.
	if (NREG != `UAA_AUX_COUNT) begin : g_bad
		$error("aux file must hold exactly eight registers");
	end

	// Register storage.
	logic [31:0] regs_q [NREG];

	// ------------------------------------------------------------------
	// One update process per entry; the add wins over a software write.
	// ------------------------------------------------------------------
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				regs_q[i] <= `UAA_ZERO32;
			end else if (add_en && add_idx == 3'(i)) begin
				regs_q[i] <= regs_q[i] + {24'h000000, add_imm};
			end else if (sw_we && sw_idx == 3'(i)) begin
				regs_q[i] <= sw_data;
			end
		end
	end

	assign rd_data = regs_q[rd_idx];

	// The selected entry grows by the immediate one edge later.
	a_aux_add: assert property (@(posedge clock) disable iff (!rst_n)
		add_en |=> regs_q[$past(add_idx)] ==
		$past(regs_q[add_idx]) + {24'h000000, $past(add_imm)})
		else $error("aux register did not grow by the immediate");

endmodule

// ===== logic/uaa_alu.sv
// Unsigned add slice: accumulator, product and auxiliary register adds.
//
// Behaviour
// - Add16 zero-extends operand into main_sum_reg.
// - Zero flag set when accumulator result is zero.
// - Negative flag copies accumulator result bit 31.
// - Carry flag follows carry out of bit 31.
// - Overflow flag sets on overflow, cleared only by writing status bit 3.
// - Add16 signed tally counts overflow when unsaturated.
// - Saturation clamps add16 accumulator result to extreme on overflow.
// - Repeat count N runs N+1 times, last flags.
// - Any intermediate overflow sets the overflow flag.
// - Repeated add16 tallies every intermediate overflow when unsaturated.
// - Add32 to product register, single cycle, unrepeatable.
// - Product add sets negative, zero from product.
// - Both add32 forms count carries in unsigned tally.
// - Repeated accumulator add32 tallies every carry.
// - Immediate zero-extended and added to aux register.
// - Three-bit pointer selects one of eight aux.
// - Unrepeatable op after prefix clears count, runs once.
`include "uaa_consts.svh"

module uaa_alu #(
	parameter int TALLY_W = `UAA_TALLY_W_DEF,
	parameter int RPT_W = `UAA_RPT_W_DEF
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Decoder side: repeat prefix.
	input wire logic repeat_prefix,
	input wire logic [RPT_W-1:0] repeat_n,
	// Decoder side: operation and operands.
	input wire logic op_valid,
	input wire logic [2:0] op_kind,
	input wire logic [15:0] mem_operand_16,
	input wire logic [31:0] mem_operand_32,
	input wire logic [7:0] op_imm8,
	output logic op_busy,
	output logic op_done
);

	// Tallies and the repeat count must fit the 32-bit read path.
	if (TALLY_W < 2 || TALLY_W > 32 || RPT_W < 1 || RPT_W > 31)
	begin : g_bad
		$error("tally or repeat width out of range");
	end

	// ------------------------------------------------------------------
	// Reset release.
	// ------------------------------------------------------------------

	// Two stages so the release of the asynchronous reset is clean.
	logic rst_meta_q;
	logic rst_sync_q;
	logic rst_s_n;

	// Assertion is immediate, release waits two edges.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_s_n = rst_sync_q;

	// ------------------------------------------------------------------
	// Architectural state.
	// ------------------------------------------------------------------
	logic [31:0] main_sum_reg_q; // Accumulator.
	logic [31:0] prod_q; // Product register.
	logic n_q; // Negative flag.
	logic z_q; // Zero flag.
	logic c_q; // Carry flag.
	logic v_q; // Sticky overflow flag.
	logic saturate_enable_q; // Saturation mode.
	logic [2:0] aux_pointer_q; // Selected aux register.
	logic [TALLY_W-1:0] ovc_q; // Signed overflow tally.
	logic [TALLY_W-1:0] unsigned_carry_tally_q; // Carry tally.
	logic [RPT_W-1:0] repeat_count_q; // Remaining repeats.

	// Sequencer state and the latched operation.
	uaa_pkg::uaa_state_e state_q;
	uaa_pkg::uaa_op_e op_q;
	logic [31:0] opnd_q; // Extended operand held over repeats.
	logic [7:0] imm_q; // Immediate for the aux add.

	// Outputs held in flops.
	logic op_busy_q;
	logic op_done_q;
	logic [31:0] rdata_q;

	// ------------------------------------------------------------------
	// Decode of the current iteration.
	// ------------------------------------------------------------------
	uaa_pkg::uaa_op_e op_in;
	logic accept;
	logic in_rptable;
	logic fire;
	logic is_acc;
	logic is_p;
	logic is_add16;
	logic is_add32;
	logic [31:0] add_lhs;
	logic [31:0] add_res;
	logic add_carry;
	logic add_ovf_pos;
	logic add_ovf_neg;
	logic add_ovf;

	assign op_in = uaa_pkg::uaa_op_e'(op_kind);

	// Only a known operation is taken, and only while idle; the unused
	// codes must not start a pass or raise a done pulse.
	assign accept = op_valid && state_q == uaa_pkg::UAA_ST_IDLE &&
		(op_in == uaa_pkg::UAA_OP_ADD16 ||
		op_in == uaa_pkg::UAA_OP_ADD32_P ||
		op_in == uaa_pkg::UAA_OP_ADD32_ACC ||
		op_in == uaa_pkg::UAA_OP_AUX_IMM);

	// Only the accumulator adds honour the repeat prefix.
	assign in_rptable = op_in == uaa_pkg::UAA_OP_ADD16 ||
		op_in == uaa_pkg::UAA_OP_ADD32_ACC;

	assign fire = state_q == uaa_pkg::UAA_ST_RUN;
	assign is_add16 = op_q == uaa_pkg::UAA_OP_ADD16;
	assign is_p = op_q == uaa_pkg::UAA_OP_ADD32_P;
	assign is_add32 = is_p || op_q == uaa_pkg::UAA_OP_ADD32_ACC;
	assign is_acc = is_add16 || op_q == uaa_pkg::UAA_OP_ADD32_ACC;
	assign add_lhs = is_p ? prod_q : main_sum_reg_q;
	assign add_ovf = add_ovf_pos || add_ovf_neg;

	// One adder serves every 32-bit form; only add16 saturates.
	uaa_adder u_adder (
		.lhs(add_lhs),
		.rhs(opnd_q),
		.sat_en(saturate_enable_q && is_add16),
		.result(add_res),
		.carry(add_carry),
		.ovf_pos(add_ovf_pos),
		.ovf_neg(add_ovf_neg)
	);

	// ------------------------------------------------------------------
	// Register port decode.
	// ------------------------------------------------------------------
	logic wr_acc;
	logic wr_prod;
	logic wr_status;
	logic wr_ctrl;
	logic wr_ovc;
	logic wr_uct;
	logic wr_aux;
	logic [31:0] aux_rd_data;

	assign wr_acc = reg_wr && reg_addr == `UAA_OFF_ACC;
	assign wr_prod = reg_wr && reg_addr == `UAA_OFF_PROD;
	assign wr_status = reg_wr && reg_addr == `UAA_OFF_STATUS;
	assign wr_ctrl = reg_wr && reg_addr == `UAA_OFF_CTRL;
	assign wr_ovc = reg_wr && reg_addr == `UAA_OFF_OVC;
	assign wr_uct = reg_wr && reg_addr == `UAA_OFF_UCT;
	assign wr_aux = reg_wr && reg_addr[7:5] == `UAA_AUX_PAGE;

	// Aux registers; the immediate add targets the pointed entry.
	uaa_aux_file u_aux (
		.clock(clock),
		.rst_n(rst_s_n),
		.sw_we(wr_aux),
		.sw_idx(reg_addr[4:2]),
		.sw_data(reg_wdata),
		.add_en(fire && op_q == uaa_pkg::UAA_OP_AUX_IMM),
		.add_idx(aux_pointer_q),
		.add_imm(imm_q),
		.rd_idx(reg_addr[4:2]),
		.rd_data(aux_rd_data)
	);

	// ------------------------------------------------------------------
	// Sequencer: accept, then one iteration per edge while running.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			state_q <= uaa_pkg::UAA_ST_IDLE;
			op_q <= uaa_pkg::UAA_OP_NONE;
			opnd_q <= `UAA_ZERO32;
			imm_q <= 8'h00;
			op_busy_q <= 1'b0;
			op_done_q <= 1'b0;
		end else begin
			op_done_q <= 1'b0;
			case (state_q)
				uaa_pkg::UAA_ST_IDLE: begin
					if (accept) begin
						state_q <= uaa_pkg::UAA_ST_RUN;
						op_busy_q <= 1'b1;
						op_q <= op_in;
						imm_q <= op_imm8;
						// The 16-bit operand enters with zero upper half.
						if (op_in == uaa_pkg::UAA_OP_ADD16) begin
							opnd_q <= {16'h0000, mem_operand_16};
						end else begin
							opnd_q <= mem_operand_32;
						end
					end
				end
				uaa_pkg::UAA_ST_RUN: begin
					// The last pass is the one with no repeats left.
					if (repeat_count_q == '0) begin
						state_q <= uaa_pkg::UAA_ST_IDLE;
						op_busy_q <= 1'b0;
						op_done_q <= 1'b1;
					end
				end
				default: begin
					state_q <= uaa_pkg::UAA_ST_IDLE;
					op_busy_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Repeat count: loaded by the prefix, spent by each extra pass.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			repeat_count_q <= '0;
		end else if (accept && !in_rptable) begin
			repeat_count_q <= '0;
		end else if (fire && repeat_count_q != '0) begin
			repeat_count_q <= repeat_count_q - 1'b1;
		end else if (repeat_prefix && !accept &&
			state_q == uaa_pkg::UAA_ST_IDLE) begin
			// A prefix beside an accepted op would change its pass count.
			repeat_count_q <= repeat_n;
		end
	end

	// ------------------------------------------------------------------
	// Accumulator and product; an add in flight beats a software write.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			main_sum_reg_q <= `UAA_ZERO32;
			prod_q <= `UAA_ZERO32;
		end else begin
			if (fire && is_acc) begin
				main_sum_reg_q <= add_res;
			end else if (wr_acc) begin
				main_sum_reg_q <= reg_wdata;
			end
			if (fire && is_p) begin
				prod_q <= add_res;
			end else if (wr_prod) begin
				prod_q <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Flags. Each pass overwrites N, Z, C, so the last pass shows.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			n_q <= 1'b0;
			z_q <= 1'b0;
			c_q <= 1'b0;
		end else if (fire && (is_acc || is_p)) begin
			n_q <= add_res[31];
			z_q <= add_res == `UAA_ZERO32;
			c_q <= add_carry;
		end
	end

	// Overflow is sticky; a set in the clearing cycle wins.
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			v_q <= 1'b0;
		end else if (fire && (is_acc || is_p) && add_ovf) begin
			v_q <= 1'b1;
		end else if (wr_status && reg_wdata[`UAA_ST_V]) begin
			v_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Tallies. Both count on every pass, not just the last one.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ovc_q <= '0;
		end else if (fire && is_add16 && !saturate_enable_q && add_ovf_pos) begin
			ovc_q <= ovc_q + 1'b1;
		end else if (fire && is_add16 && !saturate_enable_q && add_ovf_neg) begin
			ovc_q <= ovc_q - 1'b1;
		end else if (wr_ovc) begin
			ovc_q <= reg_wdata[TALLY_W-1:0];
		end
	end

	// Carry tally ignores saturation mode entirely.
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			unsigned_carry_tally_q <= '0;
		end else if (fire && is_add32 && add_carry) begin
			unsigned_carry_tally_q <= unsigned_carry_tally_q + 1'b1;
		end else if (wr_uct) begin
			unsigned_carry_tally_q <= reg_wdata[TALLY_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Control register: saturation mode and aux pointer.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			saturate_enable_q <= 1'b0;
			aux_pointer_q <= 3'h0;
		end else if (wr_ctrl) begin
			saturate_enable_q <= reg_wdata[`UAA_CTL_SAT];
			aux_pointer_q <= reg_wdata[`UAA_CTL_PTR_HI:`UAA_CTL_PTR_LO];
		end
	end

	// ------------------------------------------------------------------
	// Read data: valid only in the cycle after the strobe, else zero.
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rdata_q <= `UAA_ZERO32;
		end else if (!reg_rd) begin
			rdata_q <= `UAA_ZERO32;
		end else if (reg_addr[7:5] == `UAA_AUX_PAGE) begin
			rdata_q <= aux_rd_data;
		end else begin
			case (reg_addr)
				`UAA_OFF_ACC: rdata_q <= main_sum_reg_q;
				`UAA_OFF_PROD: rdata_q <= prod_q;
				`UAA_OFF_STATUS: rdata_q <= {28'h0000000, v_q, c_q, z_q, n_q};
				`UAA_OFF_CTRL: rdata_q <= {25'h0000000, aux_pointer_q,
					3'h0, saturate_enable_q};
				`UAA_OFF_OVC: rdata_q <= 32'(ovc_q);
				`UAA_OFF_UCT: rdata_q <= 32'(unsigned_carry_tally_q);
				`UAA_OFF_RPT: rdata_q <= 32'(repeat_count_q);
				default: rdata_q <= `UAA_ZERO32;
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign op_busy = op_busy_q;
	assign op_done = op_done_q;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_s_n);

	// Helper: passes run for the current operation and its target.
	logic [RPT_W:0] passes_q;
	logic [RPT_W:0] want_q;

	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			passes_q <= '0;
			want_q <= '0;
		end else if (accept) begin
			passes_q <= '0;
			want_q <= in_rptable ? {1'b0, repeat_count_q} + 1'b1 : 1'b1;
		end else if (fire) begin
			passes_q <= passes_q + 1'b1;
		end
	end

	// An unrepeatable op clears the count and finishes after one pass.
	sequence s_one_pass;
		repeat_count_q == '0 ##1 op_done_q && !op_busy_q;
	endsequence

	a_zero_flag: assert property (
		fire && is_acc |=> z_q == (main_sum_reg_q == `UAA_ZERO32))
		else $error("zero flag does not match accumulator");
	a_neg_flag: assert property (
		fire && is_p |=> n_q == prod_q[31] && z_q == (prod_q == '0))
		else $error("product flags do not match product");
	a_carry_flag: assert property (
		fire && is_acc |=> c_q == $past(add_carry) && n_q == main_sum_reg_q[31])
		else $error("carry or negative flag wrong after add");
	a_ovf_sticky: assert property (
		fire && add_ovf && is_acc |=> v_q [*1] ##1 (v_q || $past(wr_status)))
		else $error("overflow flag lost after overflow");
	a_tally_up: assert property (
		fire && is_add16 && !saturate_enable_q && add_ovf_pos
		|=> ovc_q == $past(ovc_q) + 1'b1)
		else $error("signed tally did not step on overflow");
	a_sat_clamp: assert property (
		fire && is_add16 && saturate_enable_q && add_ovf_pos
		|=> main_sum_reg_q == `UAA_SAT_POS && $stable(ovc_q))
		else $error("saturated result or tally wrong");
	a_repeat_len: assert property (
		op_done_q |-> passes_q == want_q)
		else $error("pass count differs from repeat count plus one");
	a_single_shot: assert property (
		accept && !in_rptable |=> s_one_pass)
		else $error("unrepeatable op did not run exactly once");
	a_carry_tally: assert property (
		fire && is_add32 && add_carry
		|=> unsigned_carry_tally_q == $past(unsigned_carry_tally_q) + 1'b1)
		else $error("carry tally did not step on carry");
	a_prod_add: assert property (
		fire && is_p |=> prod_q == $past(prod_q) + $past(opnd_q) && !op_busy_q)
		else $error("product add wrong or not single pass");

endmodule

// ===== bench/uaa_dec_model.sv
// Behavioural decoder model that offers add requests to the slice.
module uaa_dec_model (
	// Clock.
	input wire logic clock,
	// Repeat prefix towards the slice.
	output logic repeat_prefix,
	output logic [7:0] repeat_n,
	// Operation request towards the slice.
	output logic op_valid,
	output logic [2:0] op_kind,
	output logic [15:0] mem_operand_16,
	output logic [31:0] mem_operand_32,
	output logic [7:0] op_imm8,
	// Status from the slice.
	input wire logic op_busy,
	input wire logic op_done
);
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Idle levels.
	// ---------------------------------------------------------------
	// Every request line starts quiet so the slice sees no stray op.
	initial begin
		repeat_prefix = 1'b0;
		repeat_n = 8'h00;
		op_valid = 1'b0;
		op_kind = 3'h0;
		mem_operand_16 = 16'h0000;
		mem_operand_32 = 32'h00000000;
		op_imm8 = 8'h00;
	end

	// ---------------------------------------------------------------
	// Request sequence.
	// ---------------------------------------------------------------
	// Operands are inverted once taken, so a slice that samples them
	// late picks up garbage instead of a lucky stale value.
	task automatic issue(input logic [2:0] kind, input logic pre,
		input logic [7:0] n, input logic [31:0] opnd, output logic late);
		logic busy_seen;
		late = 1'b1;
		if (pre) begin
			@(posedge clock);
			repeat_prefix <= 1'b1;
			repeat_n <= n;
			@(posedge clock);
			repeat_prefix <= 1'b0;
			repeat_n <= ~n;
		end
		@(posedge clock);
		op_valid <= 1'b1;
		op_kind <= kind;
		mem_operand_16 <= opnd[15:0];
		mem_operand_32 <= opnd;
		op_imm8 <= opnd[7:0];
		@(posedge clock);
		op_valid <= 1'b0;
		mem_operand_16 <= ~opnd[15:0];
		mem_operand_32 <= ~opnd;
		op_imm8 <= ~opnd[7:0];
		// Busy must stand right after the accepting edge.
		#1;
		busy_seen = op_busy === 1'b1;
		// The wait is bounded so a slice that never finishes is caught.
		for (int i = 0; i < 300; i++) begin
			@(posedge clock);
			#1;
			if (op_done === 1'b1) begin
				late = !busy_seen;
				break;
			end
		end
	endtask
endmodule

// ===== bench/tb_uaa_alu.sv
// Self-checking bench of the unsigned add slice.
`include "uaa_consts.svh"

module tb_uaa_alu;
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Signals and instances.
	// ---------------------------------------------------------------
	logic clock;
	logic rst_n;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic repeat_prefix;
	logic [7:0] repeat_n;
	logic op_valid;
	logic [2:0] op_kind;
	logic [15:0] mem_operand_16;
	logic [31:0] mem_operand_32;
	logic [7:0] op_imm8;
	logic op_busy;
	logic op_done;
	int err_count;
	int n_checks;

	uaa_alu #(.TALLY_W(8), .RPT_W(8)) uaa_alu_inst (.clock(clock),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.repeat_prefix(repeat_prefix), .repeat_n(repeat_n),
		.op_valid(op_valid), .op_kind(op_kind),
		.mem_operand_16(mem_operand_16), .mem_operand_32(mem_operand_32),
		.op_imm8(op_imm8), .op_busy(op_busy), .op_done(op_done));

	uaa_dec_model uaa_dec_model_inst (.clock(clock),
		.repeat_prefix(repeat_prefix), .repeat_n(repeat_n),
		.op_valid(op_valid), .op_kind(op_kind),
		.mem_operand_16(mem_operand_16), .mem_operand_32(mem_operand_32),
		.op_imm8(op_imm8), .op_busy(op_busy), .op_done(op_done));

	// A 4 ns period gives the 250 MHz core clock.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// Access tasks.
	// ---------------------------------------------------------------
	// Case inequality so an unknown result never passes.
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One-cycle write strobe; data is scrambled once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// Read data stands only in the cycle after the strobe.
	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(nm, exp, reg_rdata);
	endtask

	// Runs one operation through the decoder model.
	task automatic op(input logic [2:0] k, input logic pre,
		input logic [7:0] n, input logic [31:0] v);
		logic late;
		uaa_dec_model_inst.issue(k, pre, n, v, late);
		chk("op_done timely", 32'h0, {31'h0, late});
		chk("op_busy", 32'h0, {31'h0, op_busy});
	endtask

	// An unknown kind must be ignored: no busy, no done pulse.
	task automatic op_refused(input logic [2:0] k);
		logic late;
		uaa_dec_model_inst.issue(k, 1'b0, 8'h0, 32'h00000001, late);
		chk("op refused", 32'h1, {31'h0, late});
	endtask

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Tests need well under a thousand cycles; this bound cuts a hang.
	initial begin
		repeat (5000) @(posedge clock);
		err_count++;
		end_of_test();
	end

	// ---------------------------------------------------------------
	// Test sequence.
	// ---------------------------------------------------------------
	initial begin
		err_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		// The internal reset copy lifts two edges after release.
		repeat (3) @(posedge clock);
		rd_chk("acc", `UAA_OFF_ACC, 32'h0);
		rd_chk("status", `UAA_OFF_STATUS, 32'h0);
		rd_chk("ovc", `UAA_OFF_OVC, 32'h0);
		rd_chk("unmapped", 8'h40, 32'h0);
		// Carry out of bit 31 lands exactly on zero.
		wr(`UAA_OFF_ACC, 32'hfffffff0);
		op(uaa_pkg::UAA_OP_ADD16, 1'b0, 8'h0, 32'h00000010);
		rd_chk("acc", `UAA_OFF_ACC, 32'h0);
		rd_chk("status", `UAA_OFF_STATUS, 32'h6);
		// Operand 0xffff catches sign extension; positive overflow.
		wr(`UAA_OFF_ACC, 32'h7fffffff);
		op(uaa_pkg::UAA_OP_ADD16, 1'b0, 8'h0, 32'h0000ffff);
		rd_chk("acc", `UAA_OFF_ACC, 32'h8000fffe);
		rd_chk("status", `UAA_OFF_STATUS, 32'h9);
		rd_chk("ovc", `UAA_OFF_OVC, 32'h1);
		// A clean add keeps the overflow flag.
		wr(`UAA_OFF_ACC, 32'h0);
		op(uaa_pkg::UAA_OP_ADD16, 1'b0, 8'h0, 32'h00000005);
		rd_chk("status", `UAA_OFF_STATUS, 32'h8);
		// Saturation clamps and leaves the signed tally alone.
		wr(`UAA_OFF_CTRL, 32'h1);
		wr(`UAA_OFF_ACC, 32'h7fffff00);
		op(uaa_pkg::UAA_OP_ADD16, 1'b0, 8'h0, 32'h00000100);
		rd_chk("acc", `UAA_OFF_ACC, 32'h7fffffff);
		rd_chk("ovc", `UAA_OFF_OVC, 32'h1);
		// Three passes; only the middle one overflows.
		wr(`UAA_OFF_CTRL, 32'h0);
		wr(`UAA_OFF_STATUS, 32'h8);
		wr(`UAA_OFF_ACC, 32'h7ffffffe);
		op(uaa_pkg::UAA_OP_ADD16, 1'b1, 8'h2, 32'h00000001);
		rd_chk("acc", `UAA_OFF_ACC, 32'h80000001);
		rd_chk("status", `UAA_OFF_STATUS, 32'h9);
		rd_chk("ovc", `UAA_OFF_OVC, 32'h2);
		// Two passes with saturation on: first carries, last does not.
		wr(`UAA_OFF_CTRL, 32'h1);
		wr(`UAA_OFF_STATUS, 32'h8);
		wr(`UAA_OFF_ACC, 32'h80000000);
		op(uaa_pkg::UAA_OP_ADD32_ACC, 1'b1, 8'h1, 32'h80000000);
		rd_chk("acc", `UAA_OFF_ACC, 32'h80000000);
		rd_chk("status", `UAA_OFF_STATUS, 32'h9);
		rd_chk("uct", `UAA_OFF_UCT, 32'h1);
		// A prefix before the product add must not repeat it.
		wr(`UAA_OFF_STATUS, 32'h8);
		wr(`UAA_OFF_PROD, 32'hffffffff);
		op(uaa_pkg::UAA_OP_ADD32_P, 1'b1, 8'h3, 32'h00000001);
		rd_chk("prod", `UAA_OFF_PROD, 32'h0);
		rd_chk("status", `UAA_OFF_STATUS, 32'h6);
		rd_chk("uct", `UAA_OFF_UCT, 32'h2);
		rd_chk("rpt", `UAA_OFF_RPT, 32'h0);
		// Each pointer value steers its own immediate add.
		for (int i = 0; i < 8; i++) begin
			wr(`UAA_OFF_CTRL, {25'h0, i[2:0], 4'h0});
			op(uaa_pkg::UAA_OP_AUX_IMM, 1'b0, 8'h0, 32'(i + 1));
		end
		op(uaa_pkg::UAA_OP_AUX_IMM, 1'b0, 8'h0, 32'h000000ff);
		for (int i = 0; i < 8; i++) begin
			rd_chk("aux", 8'(8'h20 + 4 * i),
				(i == 7) ? 32'h107 : 32'(i + 1));
		end
		// Unused operation code 5 leaves the accumulator and flags alone.
		op_refused(3'h5);
		rd_chk("acc", `UAA_OFF_ACC, 32'h80000000);
		rd_chk("status", `UAA_OFF_STATUS, 32'h6);
		end_of_test();
	end
endmodule
